// File: hw/aabe_pkg.sv
package aabe_pkg;
    // Widths
    localparam int DATA_W = 8;
    localparam int INSTR_W = 16;
    localparam int PC_W = 21;
    localparam int BANK_W = 4;
    localparam int FADDR_W = 12;
    localparam int FLAG_W = 5;

    // Status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;

    // Opcode fields
    localparam logic [5:0] OPC_ADD_ACC_FILE_CARRY = 6'h08;
    localparam logic [5:0] OPC_AND_ACC_FILE = 6'h05;
    localparam logic [7:0] OPC_AND_ACC_LITERAL = 8'h0B;
    localparam logic [3:0] OPC_CLEAR_FILE_BIT = 4'h9;
    localparam logic [7:0] OPC_BRANCH_ON_CARRY = 8'hE2;
    localparam logic [7:0] OPC_BRANCH_ON_NO_CARRY = 8'hE3;
    localparam logic [7:0] OPC_BRANCH_ON_NEGATIVE = 8'hE6;
    localparam logic [7:0] OPC_BRANCH_ON_NON_NEGATIVE = 8'hE7;

    // Instruction bit positions
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    localparam int BITSEL_LSB = 9;

    // Access bank split: low part in bank 0, high part in the top bank
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    // Reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [11:0] FADDR_RESET = 12'h000;
    localparam logic [20:0] PC_RESET = 21'h00_0000;

    // Flag groups each instruction may change
    localparam logic [4:0] MASK_ARITH = 5'h1F;
    localparam logic [4:0] MASK_LOGIC = 5'h14;
    localparam logic [4:0] MASK_NONE = 5'h00;

    typedef enum logic [3:0] {
        AABE_OP_NONE,
        AABE_OP_ADDC,
        AABE_OP_ANDL,
        AABE_OP_ANDF,
        AABE_OP_BCLR,
        AABE_OP_BC,
        AABE_OP_BNC,
        AABE_OP_BN,
        AABE_OP_BNN
    } aabe_op_t;

    typedef enum logic [0:0] {
        AABE_ST_EXEC,
        AABE_ST_BRANCH_NOP
    } aabe_state_t;
endpackage : aabe_pkg

// File: hw/aabe_alu_if.sv
`timescale 1ns/100ps
`default_nettype none
interface aabe_alu_if;
    import aabe_pkg::*;
    aabe_op_t op;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] operand;
    logic [2:0] bit_sel;
    logic carry_in;
    logic [DATA_W-1:0] result;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] flag_mask;

    modport core (output op, output acc, output operand, output bit_sel, output carry_in,
                  input result, input flags, input flag_mask);
    modport alu (input op, input acc, input operand, input bit_sel, input carry_in,
                 output result, output flags, output flag_mask);
endinterface : aabe_alu_if
`default_nettype wire

// File: hw/aabe_alu.sv
`timescale 1ns/100ps
`default_nettype none
module aabe_alu (
    // Operands in, result and flags out
    aabe_alu_if.alu alu
);
    import aabe_pkg::*;

    wire [DATA_W:0] sum = {1'b0, alu.acc} + {1'b0, alu.operand} + {{DATA_W{1'b0}}, alu.carry_in};
    wire [4:0] low_sum = {1'b0, alu.acc[3:0]} + {1'b0, alu.operand[3:0]} + {4'h0, alu.carry_in};
    wire [DATA_W-1:0] and_val = alu.acc & alu.operand;
    wire [DATA_W-1:0] clr_mask = ~(8'h01 << alu.bit_sel);
    wire is_add = (alu.op == AABE_OP_ADDC);
    wire is_and = (alu.op == AABE_OP_ANDL) || (alu.op == AABE_OP_ANDF);
    wire is_clr = (alu.op == AABE_OP_BCLR);
    wire [DATA_W-1:0] res = is_add ? sum[DATA_W-1:0] : is_and ? and_val : alu.operand & clr_mask; // [RQ6]
    wire ovf = (alu.acc[DATA_W-1] == alu.operand[DATA_W-1]) && (sum[DATA_W-1] != alu.acc[DATA_W-1]);

    // Flags gathered in one vector so the interface variable has a single driver
    logic [FLAG_W-1:0] flag_vec;
    always_comb begin
        flag_vec = FLAGS_RESET;
        flag_vec[FLAG_C] = sum[DATA_W]; // [RQ1]
        flag_vec[FLAG_DC] = low_sum[4];
        flag_vec[FLAG_Z] = (res == ACC_RESET);
        flag_vec[FLAG_OV] = ovf;
        flag_vec[FLAG_N] = res[DATA_W-1];
    end

    assign alu.result = res;
    assign alu.flags = flag_vec;
    // Logic ops touch only N and Z; bit clear touches nothing
    assign alu.flag_mask = is_add ? MASK_ARITH : is_and ? MASK_LOGIC : MASK_NONE; // [RQ2] [RQ3] [RQ6]
    wire unused_clr = is_clr;
endmodule : aabe_alu
`default_nettype wire

// File: hw/aabe_exec.sv
// Summary of operation
// (RQ1) Add-with-carry adds accumulator, file byte and carry; updates N, OV, C, DC, Z.
// (RQ2) Literal AND writes accumulator AND literal to accumulator; only N and Z change.
// (RQ3) File AND puts accumulator AND file byte in destination; only N and Z change.
// (RQ4) Destination bit 0 selects accumulator, bit 1 writes back to the file register.
// (RQ5) Access bit 0 selects the access bank, 1 uses the bank select register.
// (RQ6) Bit clear forces the chosen bit of the file register low; flags untouched.
// (RQ7) Branch on carry is taken only when carry is set.
// (RQ8) Branch on no carry is taken only when carry is clear.
// (RQ9) Branch on negative is taken only when negative is set.
// (RQ10) Branch on non-negative is taken only when negative is clear.
// (RQ11) Target is incremented PC plus twice signed offset; branches leave flags alone.
// (RQ12) Untaken branch takes one cycle; taken branch two, second a no-operation.
// (RQ13) On a taken branch the prefetched instruction is discarded.
`timescale 1ns/100ps
`default_nettype none
module aabe_exec (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Fetch stage
    input wire logic instr_valid,
    input wire logic [aabe_pkg::INSTR_W-1:0] instr_word,
    input wire logic [aabe_pkg::PC_W-1:0] pc_inc,
    output logic exec_nop,
    output logic branch_taken,
    output logic [aabe_pkg::PC_W-1:0] branch_target,
    // Banked data memory
    input wire logic [aabe_pkg::BANK_W-1:0] bank_select_reg,
    output logic [aabe_pkg::FADDR_W-1:0] file_rd_addr,
    input wire logic [aabe_pkg::DATA_W-1:0] file_rd_data,
    output logic file_wr_en,
    output logic [aabe_pkg::FADDR_W-1:0] file_wr_addr,
    output logic [aabe_pkg::DATA_W-1:0] file_wr_data,
    // Architectural state
    output logic [aabe_pkg::DATA_W-1:0] acc_out,
    output logic [aabe_pkg::FLAG_W-1:0] status_out
);
    import aabe_pkg::*;

    aabe_state_t state;
    aabe_state_t next_state;
    logic [DATA_W-1:0] acc;
    logic [FLAG_W-1:0] flags;
    logic wr_en;
    logic [FADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic br_taken;
    logic [PC_W-1:0] br_target;

    aabe_alu_if alu_bus ();

    // Opcode decode
    wire [7:0] opc_hi = instr_word[15:8];
    wire [7:0] file_field = instr_word[7:0];
    wire dec_addc = (instr_word[15:10] == OPC_ADD_ACC_FILE_CARRY);
    wire dec_andf = (instr_word[15:10] == OPC_AND_ACC_FILE);
    wire dec_andl = (opc_hi == OPC_AND_ACC_LITERAL);
    wire dec_bclr = (instr_word[15:12] == OPC_CLEAR_FILE_BIT);
    wire dec_bc = (opc_hi == OPC_BRANCH_ON_CARRY);
    wire dec_bnc = (opc_hi == OPC_BRANCH_ON_NO_CARRY);
    wire dec_bn = (opc_hi == OPC_BRANCH_ON_NEGATIVE);
    wire dec_bnn = (opc_hi == OPC_BRANCH_ON_NON_NEGATIVE);

    // The instruction fetched behind a taken branch is dropped here
    wire in_nop = (state == AABE_ST_BRANCH_NOP);
    wire issue = instr_valid && !in_nop; // [RQ13]

    aabe_op_t dec_op;
    assign dec_op = !issue ? AABE_OP_NONE :
                    dec_addc ? AABE_OP_ADDC :
                    dec_andf ? AABE_OP_ANDF :
                    dec_andl ? AABE_OP_ANDL :
                    dec_bclr ? AABE_OP_BCLR :
                    dec_bc ? AABE_OP_BC :
                    dec_bnc ? AABE_OP_BNC :
                    dec_bn ? AABE_OP_BN :
                    dec_bnn ? AABE_OP_BNN : AABE_OP_NONE;

    // Bank selection
    wire access_sel = instr_word[ACCESS_BIT];
    wire [BANK_W-1:0] access_bank = (file_field < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
    wire [BANK_W-1:0] eff_bank = access_sel ? bank_select_reg : access_bank; // [RQ5]
    wire [FADDR_W-1:0] eff_addr = {eff_bank, file_field};

    // Forward a write still in flight so back-to-back ops see fresh data
    wire fwd_hit = wr_en && (wr_addr == eff_addr);
    wire [DATA_W-1:0] file_val = fwd_hit ? wr_data : file_rd_data;

    wire is_lit = (dec_op == AABE_OP_ANDL);
    wire uses_file = (dec_op == AABE_OP_ADDC) || (dec_op == AABE_OP_ANDF) || (dec_op == AABE_OP_BCLR);
    wire is_alu = uses_file || is_lit;

    assign alu_bus.op = dec_op;
    assign alu_bus.acc = acc;
    assign alu_bus.operand = is_lit ? file_field : file_val;
    assign alu_bus.bit_sel = instr_word[BITSEL_LSB+2:BITSEL_LSB];
    assign alu_bus.carry_in = flags[FLAG_C]; // [RQ1]

    aabe_alu u_alu (
        .alu(alu_bus.alu)
    );

    // Destination: bit clear always writes the file; literal AND always the accumulator
    wire dest_file = (dec_op == AABE_OP_BCLR) || (uses_file && instr_word[DEST_BIT]); // [RQ4]
    wire dest_acc = is_alu && !dest_file; // [RQ2] [RQ4]

    // Branch condition
    wire cond_met = ((dec_op == AABE_OP_BC) && flags[FLAG_C]) || // [RQ7]
                    ((dec_op == AABE_OP_BNC) && !flags[FLAG_C]) || // [RQ8]
                    ((dec_op == AABE_OP_BN) && flags[FLAG_N]) || // [RQ9]
                    ((dec_op == AABE_OP_BNN) && !flags[FLAG_N]); // [RQ10]
    wire [PC_W-1:0] offset2 = {{(PC_W-9){file_field[7]}}, file_field, 1'b0};
    wire [PC_W-1:0] next_target = pc_inc + offset2; // [RQ11]

    wire [FLAG_W-1:0] next_flags = (flags & ~alu_bus.flag_mask) | (alu_bus.flags & alu_bus.flag_mask); // [RQ11]

    // A taken branch costs one extra cycle as a no-operation
    assign next_state = cond_met ? AABE_ST_BRANCH_NOP : AABE_ST_EXEC; // [RQ12]

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state <= AABE_ST_EXEC;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            acc <= ACC_RESET;
            flags <= FLAGS_RESET;
        end else begin
            if (dest_acc) begin
                acc <= alu_bus.result;
            end
            if (is_alu) begin
                flags <= next_flags; // [RQ1] [RQ3] [RQ6]
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wr_en <= 1'b0;
            wr_addr <= FADDR_RESET;
            wr_data <= ACC_RESET;
        end else begin
            wr_en <= dest_file;
            if (dest_file) begin
                wr_addr <= eff_addr;
                wr_data <= alu_bus.result; // [RQ4] [RQ6]
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            br_taken <= 1'b0;
            br_target <= PC_RESET;
        end else begin
            br_taken <= cond_met; // [RQ12]
            if (cond_met) begin
                br_target <= next_target;
            end
        end
    end

    assign exec_nop = in_nop;
    assign branch_taken = br_taken;
    assign branch_target = br_target;
    assign file_rd_addr = eff_addr;
    assign file_wr_en = wr_en;
    assign file_wr_addr = wr_addr;
    assign file_wr_data = wr_data;
    assign acc_out = acc;
    assign status_out = flags;
endmodule : aabe_exec
`default_nettype wire

// File: test/aabe_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module aabe_mem_model
import aabe_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [FADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [FADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data
);
    logic [DATA_W-1:0] mem [4096];
    // Each byte starts as its own low address byte, so the bench knows it
    initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0];
    assign rd_data = mem[rd_addr];
    always @(posedge sys_clk) if (wr_en) mem[wr_addr] <= wr_data;
endmodule : aabe_mem_model
`default_nettype wire

// File: test/aabe_exec_sva.sv
`timescale 1ns/100ps
`default_nettype none
module aabe_exec_sva
import aabe_pkg::*;
(
    input wire logic sys_clk, resetn, instr_valid, exec_nop, branch_taken, file_wr_en,
    input wire logic [INSTR_W-1:0] instr_word,
    input wire logic [PC_W-1:0] pc_inc, branch_target,
    input wire logic [BANK_W-1:0] bank_select_reg,
    input wire logic [FADDR_W-1:0] file_rd_addr, file_wr_addr,
    input wire logic [DATA_W-1:0] file_rd_data, file_wr_data, acc_out,
    input wire logic [FLAG_W-1:0] status_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire logic go = instr_valid && !exec_nop;
    wire logic [7:0] hi = instr_word[15:8];
    wire logic is_bc = go && hi == OPC_BRANCH_ON_CARRY;
    wire logic is_bnc = go && hi == OPC_BRANCH_ON_NO_CARRY;
    wire logic is_bn = go && hi == OPC_BRANCH_ON_NEGATIVE;
    wire logic is_bnn = go && hi == OPC_BRANCH_ON_NON_NEGATIVE;
    wire logic is_clr = go && instr_word[15:12] == OPC_CLEAR_FILE_BIT;
    wire logic is_fop = go && (is_clr || instr_word[15:10] == OPC_ADD_ACC_FILE_CARRY
        || instr_word[15:10] == OPC_AND_ACC_FILE);
    AST_BC: assert property (is_bc |=> branch_taken == $past(status_out[FLAG_C]))
        else $error("carry branch decision wrong");
    AST_BNC: assert property (is_bnc |=> branch_taken == !$past(status_out[FLAG_C]))
        else $error("no-carry branch decision wrong");
    AST_BN: assert property (is_bn |=> branch_taken == $past(status_out[FLAG_N]))
        else $error("negative branch decision wrong");
    AST_BNN: assert property (is_bnn |=> branch_taken == !$past(status_out[FLAG_N]))
        else $error("non-negative branch decision wrong");
    AST_TARGET: assert property (branch_taken |-> branch_target == $past(pc_inc)
        + {{12{$past(instr_word[7])}}, $past(instr_word[7:0]), 1'b0}) else $error("branch target wrong");
    AST_BR_FLAGS: assert property (is_bc || is_bnc || is_bn || is_bnn |=> $stable(status_out))
        else $error("branch changed flags");
    AST_NOP: assert property (branch_taken |-> exec_nop ##1 !exec_nop)
        else $error("no-op cycle length wrong");
    AST_DROP: assert property (exec_nop |=> !file_wr_en && !branch_taken && $stable(acc_out))
        else $error("word in no-op cycle had effect");
    AST_CLR: assert property (is_clr && !file_wr_en |=> file_wr_en && $stable(status_out)
        && file_wr_data == ($past(file_rd_data) & ~(8'h01 << $past(instr_word[11:9]))))
        else $error("bit clear result wrong");
    AST_ANDL: assert property (go && hi == OPC_AND_ACC_LITERAL |=>
        acc_out == ($past(acc_out) & $past(instr_word[7:0])) && status_out[FLAG_N] == acc_out[DATA_W-1]
        && status_out[FLAG_Z] == (acc_out == 8'h00) && status_out[FLAG_OV] == $past(status_out[FLAG_OV])
        && status_out[1:0] == $past(status_out[1:0]))
        else $error("literal and wrong");
    AST_BANK: assert property (is_fop && instr_word[ACCESS_BIT] |->
        file_rd_addr == {bank_select_reg, instr_word[7:0]}) else $error("banked address wrong");
    COV_TAKEN: cover property (branch_taken);
    COV_CLR: cover property (is_clr);
    COV_DROP: cover property (exec_nop && instr_valid);
endmodule : aabe_exec_sva
bind aabe_exec aabe_exec_sva u_aabe_exec_sva (
    .sys_clk(sys_clk), .resetn(resetn), .instr_valid(instr_valid), .exec_nop(exec_nop),
    .branch_taken(branch_taken), .file_wr_en(file_wr_en), .instr_word(instr_word), .pc_inc(pc_inc),
    .branch_target(branch_target), .bank_select_reg(bank_select_reg), .file_rd_addr(file_rd_addr),
    .file_wr_addr(file_wr_addr), .file_rd_data(file_rd_data), .file_wr_data(file_wr_data),
    .acc_out(acc_out), .status_out(status_out)
);
`default_nettype wire

// File: test/aabe_exec_bench.sv
`timescale 1ns/100ps
`default_nettype none
module aabe_exec_bench;
    import aabe_pkg::*;
    logic sys_clk = 0, resetn = 0, instr_valid = 0, exec_nop, branch_taken, file_wr_en;
    logic [INSTR_W-1:0] instr_word = '0;
    logic [PC_W-1:0] pc_inc = '0, branch_target;
    logic [BANK_W-1:0] bank_select_reg = 4'h3;
    logic [FADDR_W-1:0] file_rd_addr, file_wr_addr;
    logic [DATA_W-1:0] file_rd_data, file_wr_data, acc_out, acc_e = 8'h00;
    logic [FLAG_W-1:0] status_out, st_e = 5'h00;
    logic [7:0] ops [4] = '{OPC_BRANCH_ON_CARRY, OPC_BRANCH_ON_NO_CARRY, OPC_BRANCH_ON_NEGATIVE,
        OPC_BRANCH_ON_NON_NEGATIVE};
    int error_cnt = 0, checks_done = 0;
    aabe_exec u_aabe_exec (
        .sys_clk(sys_clk), .resetn(resetn),
        .instr_valid(instr_valid), .instr_word(instr_word), .pc_inc(pc_inc),
        .exec_nop(exec_nop), .branch_taken(branch_taken), .branch_target(branch_target),
        .bank_select_reg(bank_select_reg), .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data),
        .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
        .acc_out(acc_out), .status_out(status_out)
    );
    aabe_mem_model u_aabe_mem_model (.sys_clk(sys_clk), .rd_addr(file_rd_addr), .rd_data(file_rd_data),
        .wr_en(file_wr_en), .wr_addr(file_wr_addr), .wr_data(file_wr_data));
    initial forever #12.5 sys_clk = ~sys_clk;
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    task wrap_up;
        $display("checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    function logic [11:0] fa(input logic a, input logic [7:0] f);
        return a ? {bank_select_reg, f} : (f < ACCESS_SPLIT ? {ACCESS_LOW_BANK, f} : {ACCESS_HIGH_BANK, f});
    endfunction : fa
    // Every registered output back at its reset value
    task reset_seen;
        chk(acc_out, ACC_RESET, "reset accumulator");
        chk(status_out, FLAGS_RESET, "reset flags");
        chk(file_wr_en, 0, "reset write strobe");
        chk(file_wr_addr, FADDR_RESET, "reset write address");
        chk(file_wr_data, ACC_RESET, "reset write data");
        chk(branch_taken, 0, "reset branch");
        chk(branch_target, PC_RESET, "reset target");
        chk(exec_nop, 0, "reset no-op");
    endtask : reset_seen
    // Reset in mid-run, with a write and a branch target still standing
    task reset_mid;
        instr_valid = 0;
        resetn = 0;
        repeat (2) @(negedge sys_clk);
        reset_seen();
        acc_e = ACC_RESET;
        st_e = FLAGS_RESET;
        resetn = 1;
        @(negedge sys_clk);
    endtask : reset_mid
    // Entered and left at a falling edge; outputs are judged in the cycle after issue.
    // Valid stays up on return so back-to-back words never glitch it within one time step.
    task run(input logic [15:0] w, input logic [20:0] pc, input logic wr, input logic [11:0] wa,
        input logic [7:0] wd);
        instr_valid = 1;
        instr_word = w;
        pc_inc = pc;
        @(negedge sys_clk);
        chk(acc_out, acc_e, "accumulator");
        chk(status_out, st_e, "flags");
        chk(file_wr_en, wr, "write strobe");
        if (wr) begin
            chk(file_wr_addr, wa, "write address");
            chk(file_wr_data, wd, "write data");
        end
    endtask : run
    task addc(input logic d, input logic a, input logic [7:0] f);
        logic [8:0] s;
        logic [4:0] h;
        s = acc_e + f + st_e[FLAG_C];
        h = acc_e[3:0] + f[3:0] + st_e[FLAG_C];
        st_e = {s[7], acc_e[7] == f[7] && s[7] != acc_e[7], s[7:0] == 8'h00, h[4], s[8]};
        if (!d) acc_e = s[7:0];
        run({OPC_ADD_ACC_FILE_CARRY, d, a, f}, 21'h00_0000, d, fa(a, f), s[7:0]);
    endtask : addc
    task andx(input logic lit, input logic d, input logic a, input logic [7:0] f);
        logic [7:0] r;
        r = acc_e & f;
        st_e[FLAG_N] = r[7];
        st_e[FLAG_Z] = r == 8'h00;
        if (lit || !d) acc_e = r;
        if (lit) run({OPC_AND_ACC_LITERAL, f}, 21'h00_0000, 1'b0, 12'h000, 8'h00);
        else run({OPC_AND_ACC_FILE, d, a, f}, 21'h00_0000, d, fa(a, f), r);
    endtask : andx
    task branch(input logic [7:0] op, input logic [7:0] n, input logic [20:0] pc);
        logic t;
        logic [20:0] tg;
        t = (op[2] ? st_e[FLAG_N] : st_e[FLAG_C]) ^ op[0];
        tg = pc + {{12{n[7]}}, n, 1'b0};
        run({op, n}, pc, 1'b0, 12'h000, 8'h00);
        chk(branch_taken, t, "branch decision");
        chk(exec_nop, t, "no-op cycle");
        if (t) begin
            chk(branch_target, tg, "branch target");
            run({OPC_CLEAR_FILE_BIT, 3'd0, 1'b0, 8'h10}, pc, 1'b0, 12'h000, 8'h00);
            chk(exec_nop, 0, "no-op cycle end");
        end
    endtask : branch
    initial begin
        repeat (20) @(negedge sys_clk);
        resetn = 1;
        @(negedge sys_clk);
        reset_seen();
        addc(0, 0, 8'hF0);
        addc(0, 1, 8'h20);
        for (int i = 0; i < 4; i++) branch(ops[i], 8'h80, 21'h00_1000);
        addc(0, 1, 8'hE0);
        for (int i = 0; i < 4; i++) branch(ops[i], 8'h7F, 21'h1F_FF00);
        andx(1, 0, 0, 8'h0F);
        andx(0, 1, 0, 8'h05);
        andx(0, 0, 0, 8'h02);
        run({OPC_CLEAR_FILE_BIT, 3'd7, 1'b1, 8'h81}, 21'h00_0000, 1'b1, 12'h381, 8'h01);
        reset_mid();
        addc(1, 1, 8'h30);
        wrap_up();
    end
endmodule : aabe_exec_bench
`default_nettype wire
